//--- design/cycle_seq_pkg.sv
// Purpose: shared constants and types for the machine-cycle sequencer
// Assumes: one processor clock, synchronous active-high reset
// Notes:   strobes are active low, one bit each in strobe_t
package cycle_seq_pkg;

	localparam int          ADDR_W         = 20;
	localparam int          STEP_W         = 3;
	localparam logic [19:0] SLEEP_ADDR     = 20'h7ffff;
	localparam logic [7:0]  IO_UPPER_ADDR  = 8'h00;
	localparam logic [7:0]  RESET_BYTE     = 8'h00;
	localparam logic [2:0]  SYNC_RESET     = 3'h7;
	localparam logic [2:0]  STEP_RESET     = 3'h0;

	typedef enum logic [3:0] {
		cls_rot_mem, cls_rot_idx, cls_digit_rotate, cls_restart, cls_carry_force,
		cls_bit_reg, cls_bit_mem, cls_bit_idx, cls_sleep, cls_io_test,
		cls_test_reg, cls_test_imm, cls_test_mem
	} instr_class_t;

	typedef enum logic [2:0] {
		k_fetch_first, k_fetch, k_mem_read, k_mem_write, k_io_read, k_idle, k_sleep
	} cycle_kind_t;

	typedef enum logic [2:0] {
		a_pc, a_ptr, a_idx, a_sp1, a_sp2, a_io, a_sleep
	} addr_src_t;

	typedef struct packed {
		cycle_kind_t kind;
		addr_src_t   asrc;
		logic        last;
	} step_t;

	typedef struct packed {
		logic read_n;
		logic write_n;
		logic memory_request_n;
		logic io_request_n;
		logic fetch_cycle_n;
		logic halt_n;
		logic opcode_begin_marker_n;
	} strobe_t;

	localparam strobe_t STROBES_REST = 7'h7f;

endpackage

//--- design/bus_cycle_if.sv
// Purpose: carrier between the sequencer and its bus state timer
// Assumes: single clock domain
// Notes:   start and done are high one clock per machine cycle, so they stay high through back-to-back idle states
`timescale 1ns/1ps
`default_nettype none
interface bus_cycle_if;
	import cycle_seq_pkg::*;
	logic        start;
	cycle_kind_t kind;
	logic        done;
	strobe_t     strobes;
	modport seq  (output start, output kind, input done, input strobes);
	modport timer(input start, input kind, output done, output strobes);
endinterface
`default_nettype wire

//--- design/bus_state_timer.sv
// Purpose: runs one machine cycle as T1 T2 (Tw) T3, one idle state, or sleep
// Assumes: wait pin is asynchronous and active low
// Notes:   strobes come from flops and stand for the whole machine cycle
`timescale 1ns/1ps
`default_nettype none
module bus_state_timer (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       wait_n_i,
	input  wire logic       wake_i,
	bus_cycle_if.timer      bus
);
	import cycle_seq_pkg::*;

	typedef enum logic [2:0] {ts_rest, ts_t1, ts_t2, ts_tw, ts_t3, ts_idle, ts_sleep} tstate_t;

	tstate_t    state;
	logic [2:0] wait_sync;
	logic       wait_held;

	function automatic strobe_t strobes_for(input cycle_kind_t k);
		strobe_t s;
		s = STROBES_REST;
		case (k)
			k_fetch_first: begin
				s.read_n = 1'b0; s.memory_request_n = 1'b0; s.fetch_cycle_n = 1'b0;
				s.opcode_begin_marker_n = 1'b0; // RULE_01
			end
			k_fetch: begin
				s.read_n = 1'b0; s.memory_request_n = 1'b0; s.fetch_cycle_n = 1'b0;
			end
			k_mem_read: begin
				s.read_n = 1'b0; s.memory_request_n = 1'b0;
			end
			k_mem_write: begin
				s.write_n = 1'b0; s.memory_request_n = 1'b0; // RULE_02
			end
			k_io_read: begin
				s.read_n = 1'b0; s.io_request_n = 1'b0; // RULE_11
			end
			k_sleep: s.halt_n = 1'b0; // RULE_10
			default: s = STROBES_REST; // RULE_07
		endcase
		return s;
	endfunction

	// first flop feeds only the second; a change counts once second and third agree
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wait_sync <= SYNC_RESET;
			wait_held <= 1'b0;
		end else begin
			wait_sync <= {wait_sync[1:0], wait_n_i};
			if (wait_sync[1] == wait_sync[2])
				wait_held <= ~wait_sync[2];
		end
	end

	assign bus.done = (state == ts_t3) || (state == ts_idle) || (state == ts_sleep && wake_i);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state       <= ts_rest;
			bus.strobes <= STROBES_REST;
		end else if (bus.start) begin
			bus.strobes <= strobes_for(bus.kind);
			case (bus.kind)
				k_idle:  state <= ts_idle; // RULE_15
				k_sleep: state <= ts_sleep;
				default: state <= ts_t1;
			endcase
		end else begin
			case (state)
				ts_t1: state <= ts_t2; // RULE_15
				ts_t2: state <= wait_held ? ts_tw : ts_t3;
				ts_tw: state <= wait_held ? ts_tw : ts_t3;
				ts_t3, ts_idle: begin
					state       <= ts_rest;
					bus.strobes <= STROBES_REST;
				end
				ts_sleep: if (wake_i) begin
					state       <= ts_rest;
					bus.strobes <= STROBES_REST;
				end
				default: state <= ts_rest;
			endcase
		end
	end
endmodule // bus_state_timer
`default_nettype wire

//--- design/cpu_bus_cycle_sequencer.sv
// Purpose: orders the machine cycles of one instruction and drives the bus
// Assumes: the core decodes the class and supplies addresses, index sum and write byte
// Notes:   a new start is taken only while busy_o is low
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01 - first cycle fetches opcode with read, memory, fetch, begin marker low; marker high later
// RULE_02 - pointer rotate or shift: two fetches, read, idle, write at pointer
// RULE_03 - indexed rotate or shift: seven cycles, displacement read, third fetch, read, idle, write
// RULE_04 - digit rotate: two fetches, read at pointer, four idle states, write back
// RULE_05 - restart: one fetch, two idles, high byte to stack-1, low byte to stack-2
// RULE_06 - carry force: a single opcode fetch and nothing more
// RULE_07 - bit force on register: two fetches then idle with strobes high, data floated
// RULE_08 - bit force on pointer byte: two fetches, read, idle, write at pointer
// RULE_09 - indexed bit force: two fetches, displacement, third fetch, read, idle, write
// RULE_10 - sleep: after two fetches address all ones, data floated, only halt low; code drives SLEEP_ADDR 7ffff, top bit low
// RULE_11 - I/O test: two fetches, immediate read, I/O read at C with upper zero
// RULE_12 - test against register: two fetches then one idle, no operand access
// RULE_13 - test against immediate: two fetches then operand read with fetch strobe high
// RULE_14 - test against pointer byte: two fetches, idle, then read at pointer
// RULE_15 - bus cycles take T1 T2 T3 plus waits; idle state lasts one clock
module cpu_bus_cycle_sequencer (
	input  wire logic                         clk_i,
	input  wire logic                         reset_i,
	input  wire logic                         start_i,
	input  wire cycle_seq_pkg::instr_class_t  instr_class_i,
	input  wire logic [15:0]                  program_counter_i,
	input  wire logic [15:0]                  pointer_pair_i,
	input  wire logic [15:0]                  index_sum_i,
	input  wire logic [15:0]                  stack_pointer_i,
	input  wire logic [7:0]                   c_reg_i,
	input  wire logic [7:0]                   write_data_i,
	input  wire logic                         wait_n_i,
	input  wire logic                         wake_i,
	input  wire logic [7:0]                   data_i,
	output logic [cycle_seq_pkg::ADDR_W-1:0]  addr_o,
	output logic [7:0]                        data_o,
	output logic                              data_oe_o,
	output logic                              read_n_o,
	output logic                              write_n_o,
	output logic                              memory_request_n_o,
	output logic                              io_request_n_o,
	output logic                              fetch_cycle_n_o,
	output logic                              halt_n_o,
	output logic                              opcode_begin_marker_n_o,
	output logic [7:0]                        read_data_o,
	output logic                              read_valid_o,
	output logic                              busy_o,
	output logic                              done_o
);
	import cycle_seq_pkg::*;

	typedef enum logic {s_ready, s_run} seq_state_t;

	bus_cycle_if      bus ();
	seq_state_t       state;
	instr_class_t     cls;
	logic [STEP_W-1:0] step_idx;
	logic [STEP_W-1:0] next_step_idx;
	step_t            cur_step;
	step_t            next_step;
	instr_class_t     next_cls;
	logic             issue;

	function automatic step_t mk(input cycle_kind_t k, input addr_src_t a, input logic l);
		step_t s;
		s.kind = k;
		s.asrc = a;
		s.last = l;
		return s;
	endfunction

	// shared body of the read-idle-write tails at the pointer or index address
	function automatic step_t rmw(input logic [STEP_W-1:0] i, input logic [STEP_W-1:0] base,
		input addr_src_t a, input logic [STEP_W-1:0] idles);
		step_t s;
		if (i == base)
			s = mk(k_mem_read, a, 1'b0);
		else if (i <= base + idles)
			s = mk(k_idle, a_pc, 1'b0);
		else
			s = mk(k_mem_write, a, 1'b1);
		return s;
	endfunction

	function automatic step_t program_step(input instr_class_t c, input logic [STEP_W-1:0] i);
		step_t s;
		if (i == 3'h0)
			s = mk(k_fetch_first, a_pc, c == cls_carry_force); // RULE_01 RULE_06
		else if (c == cls_restart) begin
			case (i)
				3'h1, 3'h2: s = mk(k_idle, a_pc, 1'b0); // RULE_05
				3'h3:       s = mk(k_mem_write, a_sp1, 1'b0); // RULE_05
				default:    s = mk(k_mem_write, a_sp2, 1'b1); // RULE_05
			endcase
		end else if (i == 3'h1)
			s = mk(k_fetch, a_pc, 1'b0);
		else begin
			case (c)
				cls_rot_mem, cls_bit_mem: s = rmw(i, 3'h2, a_ptr, 3'h1); // RULE_02 RULE_08
				cls_digit_rotate:         s = rmw(i, 3'h2, a_ptr, 3'h4); // RULE_04
				cls_rot_idx, cls_bit_idx: begin
					if (i == 3'h2)
						s = mk(k_mem_read, a_pc, 1'b0); // RULE_03 RULE_09
					else if (i == 3'h3)
						s = mk(k_fetch, a_pc, 1'b0); // RULE_03 RULE_09
					else
						s = rmw(i, 3'h4, a_idx, 3'h1); // RULE_03 RULE_09
				end
				cls_bit_reg, cls_test_reg: s = mk(k_idle, a_pc, 1'b1); // RULE_07 RULE_12
				cls_sleep:    s = mk(k_sleep, a_sleep, 1'b1); // RULE_10
				cls_test_imm: s = mk(k_mem_read, a_pc, 1'b1); // RULE_13
				cls_io_test:  s = (i == 3'h2) ? mk(k_mem_read, a_pc, 1'b0)
					: mk(k_io_read, a_io, 1'b1); // RULE_11
				cls_test_mem: s = (i == 3'h2) ? mk(k_idle, a_pc, 1'b0)
					: mk(k_mem_read, a_ptr, 1'b1); // RULE_14
				default:      s = mk(k_idle, a_pc, 1'b1);
			endcase
		end
		return s;
	endfunction

	function automatic logic [ADDR_W-1:0] widen(input logic [15:0] a);
		return {4'h0, a};
	endfunction

	// only cycles that put a byte on the data pins hand one back to the core
	function automatic logic returns_data(input cycle_kind_t k);
		logic r;
		case (k)
			k_fetch_first, k_fetch, k_mem_read, k_io_read: r = 1'b1;
			default:                                      r = 1'b0;
		endcase
		return r;
	endfunction

	bus_state_timer timer (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.wait_n_i (wait_n_i),
		.wake_i   (wake_i),
		.bus      (bus)
	);

	// class and step restart only from the ready state, so a start while busy is refused
	always_comb begin
		next_cls      = (state == s_ready) ? instr_class_i : cls;
		next_step_idx = (state == s_ready) ? STEP_RESET : STEP_W'(step_idx + 3'h1);
		issue         = (state == s_ready) ? start_i : (bus.done && !cur_step.last);
		next_step     = program_step(next_cls, next_step_idx);
	end

	assign cur_step  = program_step(cls, step_idx);
	assign bus.start = issue;
	assign bus.kind  = next_step.kind;
	assign busy_o    = (state == s_run);
	// done marks the last clock of the last cycle, so the core may start on the next edge
	assign done_o    = (state == s_run) && bus.done && cur_step.last;

	assign read_n_o                = bus.strobes.read_n;
	assign write_n_o               = bus.strobes.write_n;
	assign memory_request_n_o      = bus.strobes.memory_request_n;
	assign io_request_n_o          = bus.strobes.io_request_n;
	assign fetch_cycle_n_o         = bus.strobes.fetch_cycle_n;
	assign halt_n_o                = bus.strobes.halt_n;
	assign opcode_begin_marker_n_o = bus.strobes.opcode_begin_marker_n;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state    <= s_ready;
			cls      <= cls_carry_force;
			step_idx <= STEP_RESET;
		end else if (issue) begin
			state    <= s_run;
			cls      <= next_cls;
			step_idx <= next_step_idx;
		end else if (done_o) begin
			state <= s_ready;
		end
	end

	// address and write data latched once per machine cycle so they hold through T3
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			addr_o    <= '0;
			data_o    <= RESET_BYTE;
			data_oe_o <= 1'b0;
		end else if (issue) begin
			case (next_step.asrc)
				a_ptr:   addr_o <= widen(pointer_pair_i);
				a_idx:   addr_o <= widen(index_sum_i);
				a_sp1:   addr_o <= widen(16'(stack_pointer_i - 16'h0001)); // RULE_05
				a_sp2:   addr_o <= widen(16'(stack_pointer_i - 16'h0002)); // RULE_05
				a_io:    addr_o <= widen({IO_UPPER_ADDR, c_reg_i}); // RULE_11
				a_sleep: addr_o <= SLEEP_ADDR; // RULE_10
				default: addr_o <= widen(program_counter_i);
			endcase
			// restart pushes the return address high byte first
			if (next_cls == cls_restart && next_step.asrc == a_sp1)
				data_o <= program_counter_i[15:8]; // RULE_05
			else if (next_cls == cls_restart)
				data_o <= program_counter_i[7:0]; // RULE_05
			else
				data_o <= write_data_i;
			data_oe_o <= (next_step.kind == k_mem_write); // RULE_07 RULE_10
		end else if (bus.done) begin
			data_oe_o <= 1'b0;
		end
	end

	// data pins are sampled at the close of T3; they are steady by then on a legal bus
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			read_data_o  <= RESET_BYTE;
			read_valid_o <= 1'b0;
		end else begin
			read_valid_o <= 1'b0;
			if (state == s_run && bus.done && returns_data(cur_step.kind)) begin
				read_data_o  <= data_i;
				read_valid_o <= 1'b1;
			end
		end
	end
endmodule // cpu_bus_cycle_sequencer
`default_nettype wire

//--- verif/mem_io_model.sv
// Purpose: memory and I/O devices on the shared bus
// Assumes: one clock
// Notes: slow mode holds wait low until 4 clocks into a cycle
`timescale 1ns/1ps
`default_nettype none
module mem_io_model (
	input  wire logic        clk_i,
	input  wire logic        slow_i,
	input  wire logic        read_n_i,
	input  wire logic        write_n_i,
	input  wire logic [19:0] addr_i,
	output logic [7:0]       data_o,
	output logic             wait_n_o
);
	logic [3:0] cnt = 4'h0;
	logic [7:0] last = 8'h00;
	// released bus toggles so a stale byte never looks valid
	assign data_o = !read_n_i ? addr_i[7:0] ^ 8'h5a : ~last;
	assign wait_n_o = !(slow_i && cnt < 4'h4);
	always @(posedge clk_i) begin
		last <= data_o;
		cnt <= (read_n_i && write_n_i) ? 4'h0 : (cnt == 4'hf ? cnt : cnt + 4'h1);
	end
endmodule // mem_io_model
`default_nettype wire

//--- verif/cpu_bus_cycle_sequencer_sva.sv
// Purpose: strobe and address checks at the sequencer ports
// Assumes: one clock, sync reset
// Notes: lengths judged only once wait has settled high
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_cycle_sequencer_sva (
	input wire logic                             clk_i,
	input wire logic                             reset_i,
	input wire logic                             wait_n_i,
	input wire logic [15:0]                      program_counter_i,
	input wire logic [15:0]                      stack_pointer_i,
	input wire logic [7:0]                       c_reg_i,
	input wire logic [cycle_seq_pkg::ADDR_W-1:0] addr_o,
	input wire logic [7:0]                       data_o,
	input wire logic                             data_oe_o,
	input wire logic                             read_n_o,
	input wire logic                             write_n_o,
	input wire logic                             memory_request_n_o,
	input wire logic                             io_request_n_o,
	input wire logic                             fetch_cycle_n_o,
	input wire logic                             halt_n_o,
	input wire logic                             opcode_begin_marker_n_o,
	input wire logic                             busy_o,
	input wire logic                             done_o
);
	import cycle_seq_pkg::*;
	logic [3:0] wait_hi;
	always_ff @(posedge clk_i) begin
		if (reset_i || !wait_n_i)
			wait_hi <= 4'h0;
		else if (wait_hi != 4'hf)
			wait_hi <= wait_hi + 4'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence s_first_fetch;
		!opcode_begin_marker_n_o [*3] ##1 opcode_begin_marker_n_o;
	endsequence
	sequence s_write_hold;
		(!write_n_o && $stable(addr_o)) [*2];
	endsequence
	a_marker_fetch: assert property (!opcode_begin_marker_n_o |-> !read_n_o && !memory_request_n_o && !fetch_cycle_n_o)
		else $error("marker without fetch strobes");
	a_marker_length: assert property ($fell(opcode_begin_marker_n_o) && wait_hi > 4'h8 |-> s_first_fetch)
		else $error("first fetch length");
	a_write_length: assert property ($fell(write_n_o) && wait_hi > 4'h8 |=> s_write_hold ##1 (write_n_o || $changed(addr_o)))
		else $error("write cycle length");
	a_idle_floats: assert property (busy_o && read_n_o && write_n_o |-> !data_oe_o && memory_request_n_o && io_request_n_o)
		else $error("idle state not quiet");
	a_sleep_bus: assert property (!halt_n_o |-> addr_o == SLEEP_ADDR && read_n_o && write_n_o && !data_oe_o && memory_request_n_o)
		else $error("sleep bus state");
	a_io_address: assert property (!io_request_n_o |-> memory_request_n_o && !read_n_o && addr_o == {4'h0, IO_UPPER_ADDR, c_reg_i})
		else $error("io read address");
	a_write_strobes: assert property (!write_n_o |-> !memory_request_n_o && read_n_o && data_oe_o)
		else $error("write strobes");
	a_restart_high: assert property (!write_n_o && addr_o[15:0] == stack_pointer_i - 16'h1 |-> data_o == program_counter_i[15:8])
		else $error("restart high byte");
	a_done_idle: assert property (done_o |=> !busy_o)
		else $error("busy after done");
endmodule // cpu_bus_cycle_sequencer_sva
bind cpu_bus_cycle_sequencer cpu_bus_cycle_sequencer_sva u_sva (.clk_i, .reset_i, .wait_n_i, .program_counter_i,
	.stack_pointer_i, .c_reg_i, .addr_o, .data_o, .data_oe_o, .read_n_o, .write_n_o, .memory_request_n_o,
	.io_request_n_o, .fetch_cycle_n_o, .halt_n_o, .opcode_begin_marker_n_o, .busy_o, .done_o);
`default_nettype wire

//--- verif/tb.sv
// Purpose: runs every instruction class and logs one letter per clock
// Assumes: memory answers address xor 5a
// Notes: sleep run is capped at three S letters
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cycle_seq_pkg::*;
	logic              clk_i = 1'b0, reset_i = 1'b1, start_i = 1'b0, wake_i = 1'b0, slow = 1'b0;
	instr_class_t      instr_class_i = cls_carry_force;
	logic [15:0]       pc = 16'h1000, ptr = 16'h2000, idx = 16'h3000, sp = 16'h4000;
	logic [7:0]        c_reg = 8'h35, wr_data = 8'h9c, data_i, read_data_o, data_o;
	logic [ADDR_W-1:0] addr_o;
	logic              wait_n_i, data_oe_o, read_n_o, write_n_o, memory_request_n_o, io_request_n_o;
	logic              fetch_cycle_n_o, halt_n_o, opcode_begin_marker_n_o, read_valid_o, busy_o, done_o;
	int                failures = 0, checks = 0, cyc = 0;
	always #4 clk_i = ~clk_i;
	cpu_bus_cycle_sequencer u_cpu_bus_cycle_sequencer (.clk_i, .reset_i, .start_i, .instr_class_i,
		.program_counter_i(pc), .pointer_pair_i(ptr), .index_sum_i(idx), .stack_pointer_i(sp), .c_reg_i(c_reg),
		.write_data_i(wr_data), .wait_n_i, .wake_i, .data_i, .addr_o, .data_o, .data_oe_o, .read_n_o, .write_n_o,
		.memory_request_n_o, .io_request_n_o, .fetch_cycle_n_o, .halt_n_o, .opcode_begin_marker_n_o,
		.read_data_o, .read_valid_o, .busy_o, .done_o);
	mem_io_model u_mem_io_model (.clk_i, .slow_i(slow), .read_n_i(read_n_o), .write_n_i(write_n_o),
		.addr_i(addr_o), .data_o(data_i), .wait_n_o(wait_n_i));
	task automatic conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			conclude();
		end
	end
	task automatic chk(input string what, input string e, input string g);
		checks++;
		if (e != g) begin
			failures++;
			$display("[ERR] %s expected %s seen %s", what, e, g);
		end
	endtask
	function automatic string squash(input string s);
		string r = "";
		foreach (s[i])
			if (i == 0 || s[i] != s[i-1])
				r = {r, string'(s[i])};
		return r;
	endfunction
	// one letter per clock: F first fetch, f fetch, R/P/X read, w/x/h/l write, C io, i idle, S sleep
	function automatic byte code();
		logic [15:0] a;
		a = addr_o[15:0];
		if (!halt_n_o)
			return "S";
		if (!io_request_n_o)
			return (addr_o == {4'h0, IO_UPPER_ADDR, c_reg}) ? "C" : "?";
		if (!write_n_o) begin
			if (a == sp - 16'h1)
				return data_o === pc[15:8] ? "h" : "?";
			if (a == sp - 16'h2)
				return data_o === pc[7:0] ? "l" : "?";
			return data_o !== wr_data ? "?" : a == ptr ? "w" : a == idx ? "x" : "?";
		end
		if (!read_n_o)
			return !opcode_begin_marker_n_o ? "F" : !fetch_cycle_n_o ? "f" : a == ptr ? "P" : a == idx ? "X" : a == pc ? "R" : "?";
		return "i";
	endfunction
	// start is held one clock into the instruction: it must be ignored while busy
	task automatic run(input instr_class_t cls, input string exp, input logic slow_in);
		string got;
		byte c;
		int s_n;
		logic [7:0] la;
		logic want_valid;
		got = "";
		s_n = 0;
		@(posedge clk_i);
		slow <= slow_in;
		wake_i <= 1'b0;
		start_i <= 1'b1;
		instr_class_i <= cls;
		pc <= pc + 16'h0111;
		wr_data <= wr_data + 8'h11;
		@(posedge clk_i);
		for (int n = 0; n < 400; n++) begin
			@(negedge clk_i);
			c = code();
			if (read_valid_o === 1'b1)
				chk("read data", $sformatf("%h", la ^ 8'h5a), $sformatf("%h", read_data_o));
			if (!read_n_o)
				la = addr_o[7:0];
			if (c == "S")
				s_n++;
			if (busy_o === 1'b1 && (c != "S" || s_n <= 3))
				got = {got, string'(c)};
			if (done_o === 1'b1)
				break;
			@(posedge clk_i);
			start_i <= 1'b0;
			wake_i <= (s_n > 5);
		end
		@(negedge clk_i);
		chk("busy after done", "0", $sformatf("%b", busy_o));
		want_valid = exp[exp.len()-1] inside {"F", "R", "P", "C"};
		chk("last read valid", $sformatf("%b", want_valid), $sformatf("%b", read_valid_o));
		if (read_valid_o === 1'b1)
			chk("last read data", $sformatf("%h", la ^ 8'h5a), $sformatf("%h", read_data_o));
		if (slow) begin
			chk("waited cycles", squash(exp), squash(got));
			chk("wait stretch", "1", $sformatf("%0d", got.len() > exp.len()));
		end else
			chk("cycle order", exp, got);
	endtask
	// reset lands in the middle of an instruction: strobes, busy, data enable, read valid and address must fall back to rest
	task automatic reset_mid();
		logic [6:0] st;
		@(posedge clk_i);
		slow <= 1'b0;
		start_i <= 1'b1;
		instr_class_i <= cls_digit_rotate;
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b1;
		start_i <= 1'b0;
		@(posedge clk_i);
		@(negedge clk_i);
		st = {read_n_o, write_n_o, memory_request_n_o, io_request_n_o, fetch_cycle_n_o, halt_n_o,
			opcode_begin_marker_n_o};
		chk("reset strobes", "1111111", $sformatf("%b", st));
		chk("reset busy oe valid", "000", $sformatf("%b", {busy_o, data_oe_o, read_valid_o}));
		chk("reset address", "00000", $sformatf("%h", addr_o));
		@(posedge clk_i);
		reset_i <= 1'b0;
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		run(cls_carry_force, "FFF", 1'b0);
		run(cls_rot_mem, "FFFfffPPPiwww", 1'b0);
		run(cls_rot_idx, "FFFfffRRRfffXXXixxx", 1'b0);
		run(cls_digit_rotate, "FFFfffPPPiiiiwww", 1'b0);
		run(cls_restart, "FFFiihhhlll", 1'b0);
		run(cls_bit_reg, "FFFfffi", 1'b0);
		run(cls_bit_mem, "FFFfffPPPiwww", 1'b0);
		run(cls_bit_idx, "FFFfffRRRfffXXXixxx", 1'b0);
		run(cls_sleep, "FFFfffSSS", 1'b0);
		run(cls_io_test, "FFFfffRRRCCC", 1'b0);
		run(cls_test_reg, "FFFfffi", 1'b0);
		run(cls_test_imm, "FFFfffRRR", 1'b0);
		run(cls_test_mem, "FFFfffiPPP", 1'b0);
		run(cls_test_imm, "FFFfffRRR", 1'b1);
		reset_mid();
		run(cls_carry_force, "FFF", 1'b0);
		conclude();
	end
endmodule // tb
`default_nettype wire
